/* File: dac_host.sv */
// Host controller that drives a quad parallel DAC through its pins.
// Assumes pins are synchronous to clk and the DAC keeps its own register rules.
`timescale 1ns/1ps
`default_nettype none
`include "dac_host_map.svh"
module dac_host (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register port.
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [`DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [`DATA_W-1:0] rdata,
    // Code pins.
    input wire logic [`CODE_W-1:0] code_bits_in,
    output logic [`CODE_W-1:0] code_bits_out,
    output logic code_bits_oe_n,
    // Range pins.
    input wire logic [`RANGE_W-1:0] range_bits_in,
    output logic [`RANGE_W-1:0] range_bits_out,
    output logic range_bits_oe_n,
    // Control pins.
    output logic [`CHAN_W-1:0] channel_select,
    output logic port_select,
    output logic load_n,
    output logic transfer_strobe,
    output logic read,
    output logic async_zero_n
);

    // ------------------------------------------------------------
    // State and phase timing.
    // ------------------------------------------------------------
    dac_host_pkg::host_s s_q;
    dac_host_pkg::host_s s_d;
    logic go;
    logic refuse;
    logic load;
    logic done;
    logic [`TMR_W-1:0] len;
    dac_host_pkg::op_e req_op;
    logic req_port;

    assign req_op = dac_host_pkg::op_e'(wdata[`CTRL_OP_LSB +: 3]);
    assign req_port = wdata[`CTRL_PORT_BIT];
    assign go = wr && (addr == `A_CTRL) && (s_q.state == dac_host_pkg::ST_IDLE);

    always_comb begin
        refuse = s_q.flow;
        if (req_op == dac_host_pkg::OP_NONE || req_op == dac_host_pkg::OP_RSVD) begin
            refuse = 1'b1;
        end else if (req_op == dac_host_pkg::OP_WR_RANGE) begin
            refuse = refuse || s_q.strap || (s_q.range > `RANGE_MAX);
        end else if (req_op == dac_host_pkg::OP_RD_IN || req_op == dac_host_pkg::OP_RD_OUT) begin
            refuse = refuse || (req_port && s_q.strap);
        end
    end

    assign load = (s_d.state != s_q.state);

    always_comb begin
        len = 8'h01;
        case (s_d.state)
            dac_host_pkg::ST_SETUP: len = 8'(`SETUP_CYC);
            dac_host_pkg::ST_STROBE: len = 8'(`STROBE_CYC);
            dac_host_pkg::ST_SELECT: len = 8'(`STROBE_CYC);
            dac_host_pkg::ST_RELEASE: len = 8'(`HOLD_CYC);
            dac_host_pkg::ST_HOLD: len = 8'(`HOLD_CYC);
            default: len = 8'h01;
        endcase
    end

    phase_timer u_timer (
        .clk(clk),
        .rst(rst),
        .load(load),
        .len(len),
        .done(done)
    );

    // ------------------------------------------------------------
    // Register port and pin sequencer.
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rdata = 32'h0000_0000;
        if (rd) begin
            if (addr == `A_CTRL) begin
                s_d.rdata = {25'h000_0000, s_q.port, s_q.chan_sel, s_q.op};
            end else if (addr == `A_CODE) begin
                s_d.rdata = {16'h0000, s_q.code};
            end else if (addr == `A_RANGE) begin
                s_d.rdata = {29'h0000_0000, s_q.range};
            end else if (addr == `A_CONFIG) begin
                s_d.rdata = {30'h0000_0000, s_q.strap, s_q.flow};
            end else if (addr == `A_STATUS) begin
                s_d.rdata = {30'h0000_0000, s_q.err, (s_q.state != dac_host_pkg::ST_IDLE)};
            end else if (addr == `A_READBACK) begin
                s_d.rdata = {16'h0000, s_q.rdbk};
            end
        end
        if (wr) begin
            if (addr == `A_CODE) begin
                s_d.code = wdata[`CODE_W-1:0];
            end else if (addr == `A_RANGE) begin
                s_d.range = wdata[`RANGE_W-1:0];
            end else if (addr == `A_CONFIG) begin
                s_d.flow = wdata[`CFG_FLOW_BIT];
                s_d.strap = wdata[`CFG_STRAP_BIT];
            end else if (addr == `A_STATUS) begin
                if (wdata[`ST_ERR_BIT]) begin
                    s_d.err = 1'b0;
                end
            end
        end
        case (s_q.state)
            dac_host_pkg::ST_IDLE: begin
                s_d.read = 1'b0;
                s_d.zero_n = 1'b1;
                s_d.range_oe_n = 1'b1;
                s_d.port_sel = 1'b0;
                s_d.code_out = s_q.code;
                s_d.code_oe_n = !s_d.flow;
                s_d.write_n = !s_d.flow;
                s_d.trans = s_d.flow;
                if (go && refuse) begin
                    s_d.err = 1'b1;
                end else if (go) begin
                    s_d.op = req_op;
                    s_d.port = req_port;
                    s_d.chan_sel = wdata[`CTRL_CHAN_LSB +: `CHAN_W];
                    s_d.state = dac_host_pkg::ST_SETUP;
                    s_d.write_n = 1'b1;
                    s_d.trans = 1'b0;
                    s_d.code_oe_n = 1'b1;
                    case (req_op)
                        dac_host_pkg::OP_WR_CODE: begin
                            s_d.port_sel = 1'b0;
                            s_d.code_oe_n = 1'b0;
                        end
                        dac_host_pkg::OP_WR_RANGE: begin
                            s_d.port_sel = 1'b1;
                            s_d.range_out = s_q.range;
                            s_d.range_oe_n = 1'b0;
                        end
                        dac_host_pkg::OP_RD_IN, dac_host_pkg::OP_RD_OUT: begin
                            s_d.port_sel = req_port;
                            s_d.read = 1'b1;
                        end
                        default: begin
                            s_d.port_sel = 1'b0;
                        end
                    endcase
                end
            end
            dac_host_pkg::ST_SETUP: begin
                if (done) begin
                    if (s_q.read) begin
                        s_d.state = dac_host_pkg::ST_SELECT;
                        s_d.trans = (s_q.op == dac_host_pkg::OP_RD_OUT);
                    end else begin
                        s_d.state = dac_host_pkg::ST_STROBE;
                        s_d.write_n = !(s_q.op == dac_host_pkg::OP_WR_CODE ||
                                        s_q.op == dac_host_pkg::OP_WR_RANGE);
                        s_d.trans = (s_q.op == dac_host_pkg::OP_UPDATE);
                        s_d.zero_n = !(s_q.op == dac_host_pkg::OP_CLEAR);
                    end
                end
            end
            dac_host_pkg::ST_STROBE: begin
                if (done) begin
                    s_d.state = dac_host_pkg::ST_HOLD;
                    s_d.write_n = 1'b1;
                    s_d.trans = 1'b0;
                    s_d.zero_n = 1'b1;
                end
            end
            dac_host_pkg::ST_SELECT: begin
                if (done) begin
                    s_d.state = dac_host_pkg::ST_RELEASE;
                    s_d.rdbk = s_q.port ? {13'h0000, range_bits_in} : code_bits_in;
                    s_d.trans = 1'b0;
                end
            end
            dac_host_pkg::ST_RELEASE: begin
                if (done) begin
                    s_d.state = dac_host_pkg::ST_HOLD;
                    s_d.read = 1'b0;
                end
            end
            dac_host_pkg::ST_HOLD: begin
                if (done) begin
                    s_d.state = dac_host_pkg::ST_IDLE;
                    s_d.code_oe_n = 1'b1;
                    s_d.range_oe_n = 1'b1;
                end
            end
            default: begin
                s_d.state = dac_host_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.code <= `CODE_RST;
            s_q.range <= `RANGE_RST;
            s_q.code_oe_n <= 1'b1;
            s_q.range_oe_n <= 1'b1;
            s_q.write_n <= 1'b1;
            s_q.zero_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------
    assign rdata = s_q.rdata;
    assign code_bits_out = s_q.code_out;
    assign code_bits_oe_n = s_q.code_oe_n;
    assign range_bits_out = s_q.range_out;
    assign range_bits_oe_n = s_q.range_oe_n;
    assign channel_select = s_q.chan_sel;
    assign port_select = s_q.port_sel;
    assign load_n = s_q.write_n;
    assign transfer_strobe = s_q.trans;
    assign read = s_q.read;
    assign async_zero_n = s_q.zero_n;

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    a_code_load_port: assert property (@(posedge clk) disable iff (rst)
        (!load_n && !port_select && !read) |-> !code_bits_oe_n && range_bits_oe_n)
        else $error("code load without driven code pins");

    a_range_load_port: assert property (@(posedge clk) disable iff (rst)
        (!load_n && port_select) |-> !range_bits_oe_n && code_bits_oe_n && !read)
        else $error("range load without driven range pins");

    a_flow_through: assert property (@(posedge clk) disable iff (rst)
        (!load_n && transfer_strobe) |-> s_q.flow && !read && !code_bits_oe_n)
        else $error("flow-through entered outside flow mode");

    a_ports_exclusive: assert property (@(posedge clk) disable iff (rst)
        !(!code_bits_oe_n && !range_bits_oe_n) && !(read && !code_bits_oe_n)
        && !(read && !range_bits_oe_n))
        else $error("two drivers on shared data lines");

    a_range_legal: assert property (@(posedge clk) disable iff (rst)
        $fell(load_n) && port_select |-> range_bits_out <= `RANGE_MAX)
        else $error("reserved range code sent");

    a_read_release: assert property (@(posedge clk) disable iff (rst)
        $fell(read) |-> !transfer_strobe && !$past(transfer_strobe))
        else $error("read dropped while transfer strobe high");

    a_strobe_width: assert property (@(posedge clk) disable iff (rst)
        $fell(load_n) && !s_q.flow |-> !load_n [*6] ##1 load_n)
        else $error("load strobe width wrong");

endmodule
`default_nettype wire

/* File: dac_host_map.svh */
// Register offsets, field positions, reset values and timing counts of the DAC host.
// Assumes a 200 MHz clock and a quad parallel DAC on the far side of the pins.
//
// How it works
// - Code load: port select low, load pulse.
// - Range load: port select high, load pulse.
// - Load low, transfer high gives flow-through.
// - Range bits may share low code lines.
// - Host never sends range codes 6 or 7.
// - Drop transfer strobe before dropping read.
`ifndef DAC_HOST_MAP_SVH
`define DAC_HOST_MAP_SVH

`define CODE_W 16
`define RANGE_W 3
`define CHAN_W 3
`define ADDR_W 8
`define DATA_W 32
`define TMR_W 8

`define A_CTRL 8'h00
`define A_CODE 8'h04
`define A_RANGE 8'h08
`define A_CONFIG 8'h0C
`define A_STATUS 8'h10
`define A_READBACK 8'h14

`define CTRL_OP_LSB 0
`define CTRL_CHAN_LSB 3
`define CTRL_PORT_BIT 6
`define CFG_FLOW_BIT 0
`define CFG_STRAP_BIT 1
`define ST_BUSY_BIT 0
`define ST_ERR_BIT 1

`define RANGE_MAX 3'h5
`define CODE_RST 16'h0000
`define RANGE_RST 3'h0

`define CLK_MHZ 200
`define SETUP_NS 15
`define STROBE_NS 30
`define HOLD_NS 10
`define NS_TO_CYC(ns) (((ns) * `CLK_MHZ + 999) / 1000)
`define SETUP_CYC `NS_TO_CYC(`SETUP_NS)
`define STROBE_CYC `NS_TO_CYC(`STROBE_NS)
`define HOLD_CYC `NS_TO_CYC(`HOLD_NS)

`endif

/* File: dac_host_pkg.sv */
// Types shared by the DAC host and its phase timer.
// Assumes dac_host_map.svh is on the include path.
`include "dac_host_map.svh"
package dac_host_pkg;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_WR_CODE = 3'h1,
        OP_WR_RANGE = 3'h2,
        OP_UPDATE = 3'h3,
        OP_RD_IN = 3'h4,
        OP_RD_OUT = 3'h5,
        OP_CLEAR = 3'h6,
        OP_RSVD = 3'h7
    } op_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SETUP = 3'h1,
        ST_STROBE = 3'h2,
        ST_SELECT = 3'h3,
        ST_RELEASE = 3'h4,
        ST_HOLD = 3'h5
    } state_e;

    typedef struct packed {
        logic [`TMR_W-1:0] cnt;
    } tmr_s;

    typedef struct packed {
        state_e state;
        op_e op;
        logic port;
        logic [`CODE_W-1:0] code;
        logic [`RANGE_W-1:0] range;
        logic flow;
        logic strap;
        logic err;
        logic [`CODE_W-1:0] rdbk;
        logic [`DATA_W-1:0] rdata;
        logic [`CODE_W-1:0] code_out;
        logic code_oe_n;
        logic [`RANGE_W-1:0] range_out;
        logic range_oe_n;
        logic [`CHAN_W-1:0] chan_sel;
        logic port_sel;
        logic write_n;
        logic trans;
        logic read;
        logic zero_n;
    } host_s;

endpackage

/* File: phase_timer.sv */
// Down counter that times each pin phase of the DAC host.
// Assumes load is pulsed in the last cycle before every phase, as its state is entered.
`timescale 1ns/1ps
`default_nettype none
`include "dac_host_map.svh"
module phase_timer (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Phase control.
    input wire logic load,
    input wire logic [`TMR_W-1:0] len,
    output logic done
);

    dac_host_pkg::tmr_s t_q;
    dac_host_pkg::tmr_s t_d;

    always_comb begin
        t_d = t_q;
        if (load) begin
            t_d.cnt = len - 8'h01;
        end else if (t_q.cnt != 8'h00) begin
            t_d.cnt = t_q.cnt - 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            t_q <= '0;
        end else begin
            t_q <= t_d;
        end
    end

    assign done = (t_q.cnt == 8'h00);

endmodule
`default_nettype wire

/* File: dac_model.sv */
// Behavioural quad DAC register file seen through its parallel pins.
// Assumes the host holds data steady around every strobe edge.
`timescale 1ns/1ps
`default_nettype none
module dac_model (
    // Clock for the floating-bus pattern.
    input wire logic clk,
    // Host side of the pins.
    input wire logic [15:0] host_code,
    input wire logic host_code_oe_n,
    input wire logic [2:0] host_range,
    input wire logic host_range_oe_n,
    input wire logic [2:0] channel_select,
    input wire logic port_select,
    input wire logic load_n,
    input wire logic transfer_strobe,
    input wire logic read,
    input wire logic async_zero_n,
    input wire logic strap,
    // Resolved pin levels.
    output logic [15:0] code_pins,
    output logic [2:0] range_pins
);
    // -------------------------------------------------------------
    // Registers and strobes.
    // -------------------------------------------------------------
    logic [15:0] code_in [4] = '{default: 16'h0000};
    logic [15:0] code_out [4] = '{default: 16'h0000};
    logic [2:0] range_in [4] = '{default: 3'h0};
    logic [2:0] range_out [4] = '{default: 3'h0};
    logic flt = 1'b0;
    logic [1:0] rch;
    int i;
    function automatic logic [15:0] zero_code(input logic [2:0] rg);
        case (rg)
            3'h2, 3'h3, 3'h4: return 16'h8000;
            3'h5: return 16'h4000;
            default: return 16'h0000;
        endcase
    endfunction
    always @(negedge load_n or posedge transfer_strobe or negedge async_zero_n) begin
        if (!async_zero_n) begin
            for (i = 0; i < 4; i++) begin
                code_in[i] = zero_code(range_out[i]);
                code_out[i] = zero_code(range_out[i]);
            end
        end else if (!read) begin
            for (i = 0; i < 4; i++) begin
                if (channel_select == 3'h7 || channel_select == 3'(i)) begin
                    if (!load_n && !port_select) code_in[i] = code_pins;
                    if (!load_n && port_select && !strap) range_in[i] = range_pins;
                    if (transfer_strobe) begin
                        code_out[i] = code_in[i];
                        range_out[i] = range_in[i];
                    end
                end
            end
        end
    end
    always @(posedge clk) flt <= ~flt;
    assign rch = (channel_select == 3'h7) ? 2'h0 : channel_select[1:0];
    always_comb begin
        code_pins = {8{flt, ~flt}};
        range_pins = {flt, ~flt, flt};
        if (!host_code_oe_n) code_pins = host_code;
        else if (read && !port_select) code_pins = transfer_strobe ? code_out[rch] : code_in[rch];
        if (!host_range_oe_n) range_pins = host_range;
        else if (read && port_select && !strap) range_pins = transfer_strobe ? range_out[rch] : range_in[rch];
    end
endmodule
`default_nettype wire

/* File: tb_dac_host.sv */
// Self-checking bench for the DAC host with a pin-level DAC model.
// Assumes the register map and timing of dac_host_map.svh.
`timescale 1ns/1ps
`default_nettype none
`include "dac_host_map.svh"
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin failures++; $display("ERROR %0t %s", $time, m); end end
module tb_dac_host;
    // -------------------------------------------------------------
    // Signals and bus tasks.
    // -------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_q = 1'b0;
    logic strap = 1'b0;
    wire logic [31:0] rdata;
    wire logic [15:0] cb_in, cb_out;
    wire logic [2:0] rb_in, rb_out, chs;
    wire logic cb_oe_n, rb_oe_n, psel, load_n, trs, rdp, zero_n;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    int k;
    logic [31:0] seed = 32'h0001_685C;
    logic [32:0] notes [$];
    logic [32:0] n;
    logic [15:0] c [4];
    logic [2:0] r [4];
    logic [15:0] v;
    logic [31:0] g;
    dac_host u_dac_host (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .code_bits_in(cb_in), .code_bits_out(cb_out), .code_bits_oe_n(cb_oe_n),
        .range_bits_in(rb_in), .range_bits_out(rb_out), .range_bits_oe_n(rb_oe_n),
        .channel_select(chs), .port_select(psel), .load_n(load_n), .transfer_strobe(trs),
        .read(rdp), .async_zero_n(zero_n));
    dac_model u_dac_model (.clk(clk), .host_code(cb_out), .host_code_oe_n(cb_oe_n),
        .host_range(rb_out), .host_range_oe_n(rb_oe_n), .channel_select(chs),
        .port_select(psel), .load_n(load_n), .transfer_strobe(trs), .read(rdp),
        .async_zero_n(zero_n), .strap(strap), .code_pins(cb_in), .range_pins(rb_in));
    always #2.5 clk = ~clk;
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function logic [15:0] zc(input logic [2:0] rg);
        return (rg == 3'h5) ? 16'h4000 : (rg >= 3'h2 && rg <= 3'h4) ? 16'h8000 : 16'h0000;
    endfunction
    task end_sim;
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a, input logic chk, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        notes.push_back({chk, e});
        @(posedge clk);
        rd <= 1'b0;
        #1 g = rdata;
    endtask
    task do_op(input logic [2:0] op, input logic [2:0] ch, input logic port);
        int i;
        wr_reg(`A_CTRL, {25'h000_0000, port, ch, op});
        for (i = 0; i < 40; i++) begin
            rd_reg(`A_STATUS, 1'b0, 32'h0000_0000);
            if (g[0] === 1'b0) break;
        end
    endtask
    task refused(input logic [2:0] op, input logic port);
        wr_reg(`A_CTRL, {25'h000_0000, port, 3'h0, op});
        rd_reg(`A_STATUS, 1'b1, 32'h0000_0002);
        wr_reg(`A_STATUS, 32'h0000_0002);
        rd_reg(`A_STATUS, 1'b1, 32'h0000_0000);
    endtask
    // -------------------------------------------------------------
    // Read data monitor and timeout.
    // -------------------------------------------------------------
    always @(posedge clk) begin
        rd_q <= rd;
        cycles <= cycles + 1;
        if (rd_q) begin
            n = notes.pop_front();
            if (n[32]) `CHK(rdata, n[31:0], "read data")
        end
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end
    // -------------------------------------------------------------
    // Scenarios.
    // -------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd_reg(`A_CTRL, 1'b1, 32'h0000_0000);
        rd_reg(`A_CONFIG, 1'b1, 32'h0000_0000);
        rd_reg(8'h20, 1'b1, 32'h0000_0000);
        `CHK({cb_oe_n, rb_oe_n, load_n, trs, rdp, zero_n}, 6'b111001, "idle pins")
        `CHK(u_dac_model.range_out[0], 3'h0, "power-up range")
        for (k = 0; k < 4; k++) begin
            g = xs();
            c[k] = g[15:0];
            r[k] = 3'(xs() % 6);
            wr_reg(`A_CODE, {16'h0000, c[k]});
            do_op(3'h1, 3'(k), 1'b0);
            `CHK(u_dac_model.code_in[k], c[k], "code load")
            `CHK(u_dac_model.code_out[k], 16'h0000, "output moved")
            wr_reg(`A_RANGE, {29'h0000_0000, r[k]});
            do_op(3'h2, 3'(k), 1'b1);
            `CHK(u_dac_model.range_in[k], r[k], "range load")
            do_op(3'h4, 3'(k), 1'b0);
            rd_reg(`A_READBACK, 1'b1, {16'h0000, c[k]});
            do_op(3'h4, 3'(k), 1'b1);
            rd_reg(`A_READBACK, 1'b1, {29'h0000_0000, r[k]});
        end
        do_op(3'h3, 3'h7, 1'b0);
        for (k = 0; k < 4; k++) begin
            `CHK({u_dac_model.code_out[k], u_dac_model.range_out[k]}, {c[k], r[k]}, "update")
            do_op(3'h5, 3'(k), 1'b1);
            rd_reg(`A_READBACK, 1'b1, {29'h0000_0000, r[k]});
        end
        g = xs();
        v = g[15:0];
        wr_reg(`A_CODE, {16'h0000, v});
        do_op(3'h1, 3'h7, 1'b0);
        for (k = 0; k < 4; k++) `CHK(u_dac_model.code_in[k], v, "broadcast")
        do_op(3'h5, 3'h7, 1'b0);
        rd_reg(`A_READBACK, 1'b1, {16'h0000, c[0]});
        do_op(3'h6, 3'h0, 1'b0);
        for (k = 0; k < 4; k++) begin
            `CHK(u_dac_model.code_out[k], zc(r[k]), "clear code")
            `CHK(u_dac_model.range_out[k], r[k], "clear range")
        end
        refused(3'h0, 1'b0);
        refused(3'h7, 1'b0);
        wr_reg(`A_RANGE, 32'h0000_0006);
        refused(3'h2, 1'b1);
        wr_reg(`A_CONFIG, 32'h0000_0001);
        @(posedge clk);
        #1;
        `CHK({cb_oe_n, load_n, trs, psel, rdp}, 5'b00100, "flow pins")
        `CHK(cb_out, v, "flow code")
        refused(3'h1, 1'b0);
        wr_reg(`A_CONFIG, 32'h0000_0000);
        @(posedge clk);
        #1;
        `CHK({cb_oe_n, load_n, trs}, 3'b110, "flow exit")
        wr_reg(`A_CONFIG, 32'h0000_0002);
        strap <= 1'b1;
        wr_reg(`A_RANGE, 32'h0000_0001);
        refused(3'h2, 1'b1);
        refused(3'h4, 1'b1);
        `CHK(u_dac_model.range_in[0], r[0], "strap range")
        end_sim();
    end
endmodule
`default_nettype wire
